//--- core/pdt_pkg.sv
/*
  package for the prescaled down timer: register map, field positions,
  reset values and timing constants.
  assumes a 100 MHz system clock and an Avalon-MM slave with 32-bit data.
*/
package pdt_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned ADDR_W          = 8;
  // printed offsets step by one, not by four: index, byte address is four times it
  localparam logic [7:0]  IDX_PRESCALER   = 8'hd2;
  localparam logic [7:0]  IDX_COUNT       = 8'hd3;
  localparam logic [7:0]  IDX_STATUS      = 8'hd4;
  localparam logic [7:0]  IDX_POWER       = 8'hd5;
  localparam logic [6:0]  PRESC_RELOAD    = 7'h7f;
  localparam logic [7:0]  COUNT_RELOAD    = 8'hff;
  localparam logic [7:0]  COUNT_ZERO      = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [7:0]  COUNT_ONE       = 8'h01;
  localparam logic [6:0]  PRESC_ZERO      = 7'h00;
  localparam logic [1:0]  POWER_RESET     = 2'h0;
  localparam int unsigned TAP_W           = 3;
  localparam int unsigned INT_DIV         = 12;
  localparam int unsigned BIT_FLAG        = 7;
  localparam int unsigned BIT_IRQ_EN      = 6;
  localparam int unsigned BIT_DIR         = 5;
  localparam int unsigned BIT_LEVEL       = 4;
  localparam int unsigned BIT_RUN         = 3;
  localparam int unsigned BIT_WAIT        = 0;
  localparam int unsigned BIT_STOP        = 1;
  typedef enum logic [1:0] {
    PDT_EVENT,
    PDT_GATED,
    PDT_OUT_LOW,
    PDT_OUT_HIGH
  } pdt_mode_t;
endpackage

//--- core/pdt_timer.sv
/*
  prescaled 8-bit down timer with 7-bit prescaler, pin modes and low power hold.
  assumes synchronous inputs, one 100 MHz clock, an Avalon-MM slave with waitrequest.
*/
// Local design decisions: the register offsets and the Avalon-MM slave port.
// Overview of operation
// - prescaler clocked by internal clock divided by twelve or the timer pin
// - prescaler decrements per input tick, reloads 7Fh after reaching zero
// - counter decrements per selected tap edge, reloads 0FFh after zero
// - tap select picks one of eight taps, divide by two to the field
// - run clear freezes counter and forces prescaler to 7Fh
// - reset sets counter to 0FFh and prescaler to 7Fh
// - with run set, prescaler write loads any value 0 to 7Fh
// - counter readable and writable at any time, independent of prescaler
// - current prescaler value readable through prescaler register
// - counter reaching zero sets flag; flag and enable raise interrupt
// - writing 00h to counter or one to status bit 7 sets flag
// - flag stays set until software clears it
// - counter write beats a simultaneous decrement to zero, no flag
// - direction and level bits decode event, gated, output low, output high
// - gated mode counts internal ticks only while pin is high
// - event mode counts rising edges of the timer pin
// - output mode uses internal ticks; flag rise latches level onto pin
// - direction set drives the pin push-pull
// - wait state does not affect timer; interrupt wakes from wait or stop
// - stop freezes timer except in event counter mode
// - status register at 0D4h, reset 00h, fields from bit 7 down
// - prescaler register bit 7 reads zero, value in bits 6 to 0
`timescale 1ns/10ps
`default_nettype none
module pdt_timer #(
  parameter int unsigned DIV = pdt_pkg::INT_DIV
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [9:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        TIMER_PIN_IN,
  output logic             TIMER_PIN_OUT,
  output logic             TIMER_PIN_OE_N,
  output logic             IRQ,
  output logic             WAKE
);
  logic [6:0]  presc_q;
  logic [7:0]  count_q;
  logic [7:0]  status_q;
  logic [1:0]  power_q;
  logic [6:0]  tap_prev_q;
  logic [3:0]  div_q;
  logic        pin_s1_q;
  logic        pin_s2_q;
  logic        pin_s3_q;
  logic        ack_q;
  logic        flag_prev_q;
  logic        int_tick;
  logic        pin_rise;
  logic        presc_tick;
  logic        cnt_tick;
  logic        hit;
  logic        wr;
  logic        rd;
  logic [7:0]  idx;
  logic [7:0]  wbyte;
  logic        wr_presc;
  logic        wr_count;
  logic        wr_status;
  logic        wr_power;
  logic        run;
  logic        stopped;
  logic [2:0]  tap_sel;
  logic [6:0]  presc_d;
  logic        dec_zero;
  logic [6:0]  wlow;
  logic        level_bit;
  pdt_pkg::pdt_mode_t mode;

  // bus decode; word index is address bits above byte lane
  assign idx       = AVS_ADDRESS[9:2];
  assign wbyte     = AVS_WRITEDATA[7:0];
  assign hit       = ack_q;
  assign wr        = AVS_WRITE && hit && AVS_BYTEENABLE[0];
  assign rd        = AVS_READ && hit;
  assign wr_presc  = wr && (idx == pdt_pkg::IDX_PRESCALER);
  assign wr_count  = wr && (idx == pdt_pkg::IDX_COUNT);
  assign wr_status = wr && (idx == pdt_pkg::IDX_STATUS);
  assign wr_power  = wr && (idx == pdt_pkg::IDX_POWER);

  assign run     = status_q[pdt_pkg::BIT_RUN];
  assign tap_sel = status_q[pdt_pkg::TAP_W-1:0];
  assign mode    = pdt_pkg::pdt_mode_t'({status_q[pdt_pkg::BIT_DIR], status_q[pdt_pkg::BIT_LEVEL]});
  assign stopped = power_q[pdt_pkg::BIT_STOP] && (mode != pdt_pkg::PDT_EVENT);
  assign wlow      = wbyte[6:0];
  assign level_bit = status_q[pdt_pkg::BIT_LEVEL];

  // one wait cycle per access, answered on the second edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack_q) begin
      unique case (idx)
        pdt_pkg::IDX_PRESCALER: AVS_READDATA <= {25'h0, presc_q};
        pdt_pkg::IDX_COUNT:     AVS_READDATA <= {24'h0, count_q};
        pdt_pkg::IDX_STATUS:    AVS_READDATA <= {24'h0, status_q};
        pdt_pkg::IDX_POWER:     AVS_READDATA <= {30'h0, power_q};
        default:                AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // internal clock divided by twelve
  always_ff @(posedge CLK) begin
    if (RST) begin
      div_q <= 4'h0;
    end else if (div_q == 4'(DIV - 1)) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign int_tick = (div_q == 4'(DIV - 1));

  // pin synchroniser and rising edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= TIMER_PIN_IN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  assign pin_rise = pin_s2_q && !pin_s3_q;

  always_comb begin
    unique case (mode)
      pdt_pkg::PDT_EVENT: presc_tick = pin_rise;
      pdt_pkg::PDT_GATED: presc_tick = int_tick && pin_s2_q;
      default:            presc_tick = int_tick;
    endcase
  end

  // prescaler
  always_comb begin
    presc_d = presc_q;
    if (!run) begin
      presc_d = pdt_pkg::PRESC_RELOAD;
    end else if (wr_presc) begin
      presc_d = wbyte[6:0];
    end else if (presc_tick && !stopped) begin
      presc_d = (presc_q == pdt_pkg::PRESC_ZERO) ? pdt_pkg::PRESC_RELOAD : presc_q - 7'h01;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      presc_q    <= pdt_pkg::PRESC_RELOAD;
      tap_prev_q <= pdt_pkg::PRESC_RELOAD;
    end else begin
      presc_q    <= presc_d;
      tap_prev_q <= presc_q;
    end
  end

  // tap: divide by 2^n; tap 0 follows each input tick
  always_comb begin
    if (tap_sel == 3'h0) begin
      cnt_tick = run && presc_tick && !stopped;
    end else begin
      cnt_tick = run && !tap_prev_q[tap_sel - 3'h1] && presc_q[tap_sel - 3'h1];
    end
  end

  assign dec_zero = cnt_tick && (count_q == pdt_pkg::COUNT_ONE);

  always_ff @(posedge CLK) begin
    if (RST) begin
      count_q <= pdt_pkg::COUNT_RELOAD;
    end else if (wr_count) begin
      count_q <= wbyte;
    end else if (cnt_tick) begin
      count_q <= (count_q == pdt_pkg::COUNT_ZERO) ? pdt_pkg::COUNT_RELOAD : count_q - 8'h01;
    end
  end

  // status register; hardware set wins over clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      status_q <= pdt_pkg::STATUS_RESET;
    end else begin
      if (wr_status) begin
        status_q <= wbyte;
      end
      if ((dec_zero && !wr_count) || (wr_count && wbyte == pdt_pkg::COUNT_ZERO)) begin
        status_q[pdt_pkg::BIT_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      power_q <= pdt_pkg::POWER_RESET;
    end else if (wr_power) begin
      power_q <= wbyte[1:0];
    end else if (status_q[pdt_pkg::BIT_FLAG] && status_q[pdt_pkg::BIT_IRQ_EN]) begin
      power_q <= pdt_pkg::POWER_RESET;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      flag_prev_q    <= 1'b0;
      TIMER_PIN_OUT  <= 1'b0;
      TIMER_PIN_OE_N <= 1'b1;
      IRQ            <= 1'b0;
      WAKE           <= 1'b0;
    end else begin
      flag_prev_q    <= status_q[pdt_pkg::BIT_FLAG];
      TIMER_PIN_OE_N <= !status_q[pdt_pkg::BIT_DIR];
      if (status_q[pdt_pkg::BIT_FLAG] && !flag_prev_q) begin
        TIMER_PIN_OUT <= status_q[pdt_pkg::BIT_LEVEL];
      end
      IRQ  <= status_q[pdt_pkg::BIT_FLAG] && status_q[pdt_pkg::BIT_IRQ_EN];
      WAKE <= status_q[pdt_pkg::BIT_FLAG] && status_q[pdt_pkg::BIT_IRQ_EN] && (|power_q);
    end
  end

  // checks
  property p_reload_presc;
    @(posedge CLK) disable iff (RST) !run |=> presc_q == pdt_pkg::PRESC_RELOAD;
  endproperty
  a_reload_presc: assert property (p_reload_presc) else $error("prescaler not held at reload");
  property p_freeze;
    @(posedge CLK) disable iff (RST) (!run && !wr_count) |=> $stable(count_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while stopped");
  property p_wrap;
    @(posedge CLK) disable iff (RST) (cnt_tick && !wr_count && count_q == pdt_pkg::COUNT_ZERO) |=>
      count_q == pdt_pkg::COUNT_RELOAD;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not reload");
  property p_flag_zero;
    @(posedge CLK) disable iff (RST) (dec_zero && !wr_count) |=> status_q[pdt_pkg::BIT_FLAG];
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("flag missing at zero");
  property p_flag_w0;
    @(posedge CLK) disable iff (RST) (wr_count && wbyte == pdt_pkg::COUNT_ZERO) |=> status_q[pdt_pkg::BIT_FLAG];
  endproperty
  a_flag_w0: assert property (p_flag_w0) else $error("flag missing on zero write");
  property p_sticky;
    @(posedge CLK) disable iff (RST) (status_q[pdt_pkg::BIT_FLAG] && !wr_status) |=> status_q[pdt_pkg::BIT_FLAG];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped on its own");
  property p_irq;
    @(posedge CLK) disable iff (RST) (status_q[pdt_pkg::BIT_FLAG] && status_q[pdt_pkg::BIT_IRQ_EN]) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_wr_wins;
    @(posedge CLK) disable iff (RST) (wr_count && dec_zero) |=> count_q == $past(wbyte);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("write lost to decrement");
  property p_oe;
    @(posedge CLK) disable iff (RST) status_q[pdt_pkg::BIT_DIR] |=> !TIMER_PIN_OE_N;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not driven in output mode");
  property p_presc_rd;
    @(posedge CLK) disable iff (RST) (AVS_READ && !ack_q && idx == pdt_pkg::IDX_PRESCALER) |=>
      AVS_READDATA[31:7] == 25'h0;
  endproperty
  a_presc_rd: assert property (p_presc_rd) else $error("prescaler upper bits nonzero");
  property p_ack_pulse;
    @(posedge CLK) disable iff (RST) !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("waitrequest low for more than one cycle");
  property p_ack_answer;
    @(posedge CLK) disable iff (RST) ((AVS_READ || AVS_WRITE) && !ack_q) |=> !AVS_WAITREQUEST;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_presc_wrap;
    @(posedge CLK) disable iff (RST) (run && presc_tick && !stopped && !wr_presc && presc_q == pdt_pkg::PRESC_ZERO)
      |=> presc_q == pdt_pkg::PRESC_RELOAD;
  endproperty
  a_presc_wrap: assert property (p_presc_wrap) else $error("prescaler did not reload");
  property p_presc_dec;
    @(posedge CLK) disable iff (RST) (run && presc_tick && !stopped && !wr_presc && presc_q != pdt_pkg::PRESC_ZERO)
      |=> presc_q == $past(presc_q) - 7'h01;
  endproperty
  a_presc_dec: assert property (p_presc_dec) else $error("prescaler did not decrement");
  property p_presc_wr;
    @(posedge CLK) disable iff (RST) (run && wr_presc) |=> presc_q == $past(wlow);
  endproperty
  a_presc_wr: assert property (p_presc_wr) else $error("prescaler write lost");
  property p_stop_hold;
    @(posedge CLK) disable iff (RST) (stopped && run && !wr_presc) |=> $stable(presc_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("prescaler moved while stopped");
  property p_event_stop;
    @(posedge CLK) disable iff (RST) (power_q[pdt_pkg::BIT_STOP] && mode == pdt_pkg::PDT_EVENT && run && pin_rise &&
      !wr_presc) |=> presc_q != $past(presc_q);
  endproperty
  a_event_stop: assert property (p_event_stop) else $error("event count lost in stop");
  property p_gate_low;
    @(posedge CLK) disable iff (RST) (mode == pdt_pkg::PDT_GATED && run && !pin_s2_q && !wr_presc)
      |=> $stable(presc_q);
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("gated prescaler moved with pin low");
  property p_gate_high;
    @(posedge CLK) disable iff (RST) (mode == pdt_pkg::PDT_GATED && run && pin_s2_q && int_tick && !stopped &&
      !wr_presc) |=> presc_q != $past(presc_q);
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("gated prescaler missed a tick");
  property p_tap0;
    @(posedge CLK) disable iff (RST) (run && tap_sel == 3'h0 && presc_tick && !stopped && !wr_count &&
      count_q != pdt_pkg::COUNT_ZERO) |=> count_q == $past(count_q) - 8'h01;
  endproperty
  a_tap0: assert property (p_tap0) else $error("counter missed a tap zero tick");
  property p_wr_count;
    @(posedge CLK) disable iff (RST) wr_count |=> count_q == $past(wbyte);
  endproperty
  a_wr_count: assert property (p_wr_count) else $error("counter write lost");
  property p_status_wr;
    @(posedge CLK) disable iff (RST) (wr_status && !dec_zero) |=> status_q == $past(wbyte);
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("status write lost");
  property p_rd_count;
    @(posedge CLK) disable iff (RST) (AVS_READ && !ack_q && idx == pdt_pkg::IDX_COUNT)
      |=> AVS_READDATA[7:0] == $past(count_q);
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("counter read wrong");
  property p_irq_off;
    @(posedge CLK) disable iff (RST) !(status_q[pdt_pkg::BIT_FLAG] && status_q[pdt_pkg::BIT_IRQ_EN])
      |=> !IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without flag and enable");
  property p_wake;
    @(posedge CLK) disable iff (RST) (status_q[pdt_pkg::BIT_FLAG] && status_q[pdt_pkg::BIT_IRQ_EN] && (|power_q))
      |=> WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from low power");
  property p_power_clr;
    @(posedge CLK) disable iff (RST) (status_q[pdt_pkg::BIT_FLAG] && status_q[pdt_pkg::BIT_IRQ_EN] && !wr_power)
      |=> power_q == pdt_pkg::POWER_RESET;
  endproperty
  a_power_clr: assert property (p_power_clr) else $error("low power state kept after interrupt");
  property p_pin_latch;
    @(posedge CLK) disable iff (RST) (status_q[pdt_pkg::BIT_FLAG] && !flag_prev_q) |=> TIMER_PIN_OUT == $past(level_bit);
  endproperty
  a_pin_latch: assert property (p_pin_latch) else $error("level not latched on flag rise");
  property p_oe_in;
    @(posedge CLK) disable iff (RST) !status_q[pdt_pkg::BIT_DIR] |=> TIMER_PIN_OE_N;
  endproperty
  a_oe_in: assert property (p_oe_in) else $error("pin driven in input mode");
  c_underflow: cover property (@(posedge CLK) disable iff (RST) dec_zero);
  c_event: cover property (@(posedge CLK) disable iff (RST) mode == pdt_pkg::PDT_EVENT && pin_rise && run);
  c_out: cover property (@(posedge CLK) disable iff (RST) status_q[5] && status_q[7] && !flag_prev_q);
  c_wr_wins: cover property (@(posedge CLK) disable iff (RST) wr_count && dec_zero);
  c_stopped: cover property (@(posedge CLK) disable iff (RST) stopped && run);
endmodule // pdt_timer
`default_nettype wire

//--- verification/tb_top.sv
/*
  self-checking bench for the prescaled down timer: registers, counting and pin modes.
  assumes pdt_pkg and pdt_timer compiled first; DIV left at its default of 12.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst;
  logic        rd;
  logic        wr;
  logic        pin;
  logic [9:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wreq;
  logic        pout;
  logic        poe_n;
  logic        irq;
  logic        wake;
  logic [7:0]  q;
  int          failures;
  int          total_checks;

  pdt_timer dut (
    .CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .TIMER_PIN_IN(pin), .TIMER_PIN_OUT(pout),
    .TIMER_PIN_OE_N(poe_n), .IRQ(irq), .WAKE(wake)
  );

  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one avalon access, held until waitrequest is low at a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    wr   <= w;
    rd   <= ~w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(nm, q, exp);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic t_reset;
    rd_chk("prescaler", pdt_pkg::IDX_PRESCALER, 8'h7f);
    rd_chk("count", pdt_pkg::IDX_COUNT, 8'hff);
    rd_chk("status", pdt_pkg::IDX_STATUS, 8'h00);
    rd_chk("unmapped", 8'hd6, 8'h00);
  endtask

  task automatic t_flag;
    bus(1'b1, pdt_pkg::IDX_COUNT, 8'h05);
    rd_chk("count", pdt_pkg::IDX_COUNT, 8'h05);
    bus(1'b1, pdt_pkg::IDX_COUNT, 8'h00);
    repeat (20) @(posedge clk);
    rd_chk("status", pdt_pkg::IDX_STATUS, 8'h80);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h00);
    rd_chk("status", pdt_pkg::IDX_STATUS, 8'h00);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'hc0);
    rd_chk("status", pdt_pkg::IDX_STATUS, 8'hc0);
    chk("irq", irq, 8'h01);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h00);
  endtask

  task automatic t_count;
    pin <= 1'b1; // gate input held high as by pull-up
    bus(1'b1, pdt_pkg::IDX_COUNT, 8'h03);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h58);
    repeat (60) @(posedge clk);
    rd_chk("status", pdt_pkg::IDX_STATUS, 8'hd8);
    chk("irq", irq, 8'h01);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h1f);
    bus(1'b1, pdt_pkg::IDX_COUNT, 8'h10);
    repeat (200) @(posedge clk);
    rd_chk("count", pdt_pkg::IDX_COUNT, 8'h10);
    chk("irq", irq, 8'h00);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h10);
    rd_chk("prescaler", pdt_pkg::IDX_PRESCALER, 8'h7f);
  endtask

  task automatic t_gate;
    pin <= 1'b0;
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h18);
    bus(1'b1, pdt_pkg::IDX_PRESCALER, 8'h85);
    repeat (50) @(posedge clk);
    rd_chk("prescaler", pdt_pkg::IDX_PRESCALER, 8'h05);
    pin <= 1'b1;
    repeat (40) @(posedge clk);
    bus(1'b0, pdt_pkg::IDX_PRESCALER, 8'h00);
    chk("gated", {7'h0, q < 8'h05}, 8'h01);
  endtask

  task automatic t_event;
    pin <= 1'b0;
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h00);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h08);
    pulses(3);
    rd_chk("prescaler", pdt_pkg::IDX_PRESCALER, 8'h7c);
    bus(1'b1, pdt_pkg::IDX_POWER, 8'h02);
    pulses(2);
    rd_chk("prescaler", pdt_pkg::IDX_PRESCALER, 8'h7a);
    bus(1'b1, pdt_pkg::IDX_POWER, 8'h00);
    bus(1'b1, pdt_pkg::IDX_COUNT, 8'h01);
    pin <= 1'b1;
    @(posedge clk);
    bus(1'b1, pdt_pkg::IDX_COUNT, 8'h40); // lands on the edge of the last decrement
    rd_chk("count", pdt_pkg::IDX_COUNT, 8'h40);
    rd_chk("status", pdt_pkg::IDX_STATUS, 8'h08);
    bus(1'b1, pdt_pkg::IDX_POWER, 8'h02);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h18);
    repeat (40) @(posedge clk);
    rd_chk("prescaler", pdt_pkg::IDX_PRESCALER, 8'h79);
    rd_chk("count", pdt_pkg::IDX_COUNT, 8'h40);
    bus(1'b1, pdt_pkg::IDX_POWER, 8'h00);
  endtask

  task automatic t_out;
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h30);
    @(posedge clk);
    chk("oe_n", poe_n, 8'h00);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'hb0);
    repeat (3) @(posedge clk);
    chk("pin", pout, 8'h01);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h20);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'ha0);
    repeat (3) @(posedge clk);
    chk("pin", pout, 8'h00);
  endtask

  task automatic t_wake;
    logic seen;
    seen = 1'b0;
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'h00);
    bus(1'b1, pdt_pkg::IDX_POWER, 8'h01);
    bus(1'b1, pdt_pkg::IDX_STATUS, 8'hc0);
    repeat (8) begin
      @(negedge clk);
      if (wake === 1'b1) seen = 1'b1;
    end
    chk("wake", seen, 8'h01);
    rd_chk("power", pdt_pkg::IDX_POWER, 8'h00);
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial begin
    clk  = 1'b0;
    rst  = 1'b1;
    rd   = 1'b0;
    wr   = 1'b0;
    pin  = 1'b0;
    adr  = 10'h000;
    wdat = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_flag();
    t_count();
    t_gate();
    t_event();
    t_out();
    t_wake();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
